/* File: verilog/putk_pkg.sv */
/*
 * Shared constants for the pattern-unlock timekeeper access sequencer.
 * Assumes a single 200 MHz clock domain and active-low asynchronous reset.
 */
`default_nettype none
package putk_pkg;
    // ************************************************************
    // Key and transfer geometry
    // ************************************************************
    localparam int unsigned KEY_BITS   = 64;                 // Bits in the unlock key.
    localparam int unsigned XFER_BITS  = 64;                 // Bits in one transfer phase.
    localparam int unsigned REG_COUNT  = 8;                  // Time registers.
    localparam int unsigned REG_WIDTH  = 8;                  // Bits per time register.
    localparam int unsigned DAY_REG    = 4;                  // Index of the day register.
    localparam int unsigned RST_EN_BIT = 4;                  // Abort-pin ignore bit in day reg.
    localparam logic [63:0] UNLOCK_KEY = 64'h5CA3_3AC5_5CA3_3AC5; // First byte in low bits.

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [5:0]  PTR_RESET   = 6'h00;              // Pointer after reset.
    localparam logic [63:0] TIME_RESET  = 64'h0000_0000_0000_0000; // Time image after reset.

    // ************************************************************
    // Sequencer states, Gray coded from idle through match to transfer
    // ************************************************************
    typedef enum logic [1:0] {
        PUTK_IDLE  = 2'b00,   // Waiting for the opening read.
        PUTK_MATCH = 2'b01,   // Comparing key bits.
        PUTK_XFER  = 2'b11,   // Time-register transfer.
        PUTK_DEAD  = 2'b10    // Mismatch seen, writes ignored.
    } putk_state_e;
endpackage
`default_nettype wire

/* File: verilog/putk_sync.sv */
/*
 * Two-flop synchroniser, one per bit through a generate loop.
 * Assumes inputs are asynchronous to mclk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module putk_sync #(
    parameter int unsigned      WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0   // Idle level of each input.
) (
    // Clock and reset.
    input  wire logic             mclk_i,
    input  wire logic             resetn_i,
    // Data.
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    // ************************************************************
    // Synchroniser stages
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic meta_q;   // First stage, read only by the second.
            logic sync_q;   // Second stage.
            // Both stages start at the input's idle level, so no false edge follows reset.
            always_ff @(posedge mclk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    meta_q <= RESET_VAL[g];
                    sync_q <= RESET_VAL[g];
                end else begin
                    meta_q <= async_i[g];
                    sync_q <= meta_q;
                end
            end
            assign sync_o[g] = sync_q;
        end
    endgenerate
endmodule
`default_nettype wire

/* File: verilog/putk_buf2.sv */
/*
 * Two-entry valid/ready buffer carrying serial output bits.
 * Assumes one clock; the drain side may stall at will.
 */
`timescale 1ns/1ps
`default_nettype none
module putk_buf2 #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             mclk_i,
    input  wire logic             resetn_i,
    // Fill side.
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side.
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o,
    // Flush.
    input  wire logic             flush_i
);
    // ************************************************************
    // Storage
    // ************************************************************
    logic [WIDTH-1:0] ent_q [2];      // Entry 0 is the head.
    logic [WIDTH-1:0] ent_d [2];
    logic [1:0]       cnt_q, cnt_d;   // Entries held.

    assign in_ready_o  = (cnt_q != 2'd2);
    assign out_valid_o = (cnt_q != 2'd0);
    assign out_data_o  = ent_q[0];

    // Next entries and count from push and pop.
    always_comb begin
        logic push;
        logic pop;
        push     = in_valid_i && in_ready_o;
        pop      = out_valid_o && out_ready_i;
        ent_d[0] = ent_q[0];
        ent_d[1] = ent_q[1];
        cnt_d    = cnt_q;
        if (pop) begin
            ent_d[0] = ent_q[1];
        end
        if (push) begin
            if (cnt_q == 2'd0 || (cnt_q == 2'd1 && pop)) begin
                ent_d[0] = in_data_i;
            end else begin
                ent_d[cnt_q[0] ? 1 : 0] = in_data_i;
            end
        end
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
        if (flush_i) begin
            cnt_d = 2'd0;
        end
    end

    // Register the buffer state.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ent_q[0] <= '0;
            ent_q[1] <= '0;
            cnt_q    <= 2'd0;
        end else begin
            ent_q <= ent_d;
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/putk_top.sv */
/*
 * Access sequencer and memory-select gating for a pattern-unlocked timekeeper.
 * Assumes bus strobes arrive asynchronously and are sampled on mclk_i;
 * the time image is held here and exposed to the counting logic outside.
 */
// What this block does
// - Selected read restarts key pointer at bit zero.
// - Key is C5 3A A3 5C twice.
// - Matching write advances pointer, awaits next.
// - Mismatch freezes pointer, ignores writes until read.
// - Read during recognition aborts, resets pointer.
// - Before unlock, memory select follows chip select.
// - Unlocked: 64 transfer cycles, memory select high.
// - Transfer write captures bit; read drives bit.
// - Deselected cycles leave pointer and count alone.
// - Key writes never alter time registers.
// - Normal supply, idle: select tracks chip select.
// - Mode input picks RAM or ROM behaviour.
// - RAM mode power fail forces select high.
// - Power fail aborts transfer, refuses access.
// - ROM mode power fail forces select low.
// - ROM mode keeps same abort and protection.
// - Power-fail comparator level reaches control logic.
// - Transfers step bit0 reg0 to bit7 reg7.
// - Abort pin honoured only when day bit clear.
`timescale 1ns/1ps
`default_nettype none
module putk_top (
    // Clock and reset.
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    // Host bus strobes and abort, all active low, and serial data, from pins.
    input  wire logic        chip_select_in_n_i,
    input  wire logic        output_gate_n_i,
    input  wire logic        write_enable_n_i,
    input  wire logic        serial_in_i,
    input  wire logic        abort_n_i,
    // Supply supervision and mode, from pins.
    input  wire logic        power_fail_i,
    input  wire logic        rom_mode_i,
    // Memory select and serial output.
    output logic             memory_select_out_n_o,
    output logic             serial_out_o,
    output logic             serial_out_oe_o,
    // Serial read stream through the buffer.
    output logic             rd_bit_valid_o,
    input  wire logic        rd_bit_ready_i,
    output logic             rd_bit_o,
    // Time image and status.
    input  wire logic [63:0] time_load_i,
    output logic      [63:0] time_image_o,
    output logic             time_update_o,
    output logic             unlocked_o
);
    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [6:0] pins_s;   // Synchronised pin levels.
    // Reset levels match the idle pins: strobes and abort high, the rest low.
    putk_sync #(.WIDTH(7), .RESET_VAL(7'h74)) u_sync (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .async_i  ({chip_select_in_n_i, output_gate_n_i, write_enable_n_i,
                    serial_in_i, abort_n_i, power_fail_i, rom_mode_i}),
        .sync_o   (pins_s)
    );

    logic cs_n_s;    // Chip select, synchronised.
    logic oe_n_s;    // Output gate, synchronised.
    logic we_n_s;    // Write enable, synchronised.
    logic din_s;     // Serial input, synchronised.
    logic abort_n_s; // Abort pin, synchronised.
    logic pfail_s;   // Power fail, synchronised.
    logic rom_s;     // Mode select, synchronised.
    assign {cs_n_s, oe_n_s, we_n_s, din_s, abort_n_s, pfail_s, rom_s} = pins_s;

    // ************************************************************
    // Bus cycle detection
    // ************************************************************
    logic rd_act;     // Read strobe combination active.
    logic wr_act;     // Write strobe combination active.
    logic rd_prev_q;  // Read active last cycle.
    logic wr_prev_q;  // Write active last cycle.
    logic rd_start;   // One-cycle pulse at a read's start.
    logic wr_start;   // One-cycle pulse at a write's start.

    // Only cycles with chip select count; others pass untouched.
    assign rd_act   = !cs_n_s && !oe_n_s && we_n_s;
    assign wr_act   = !cs_n_s && !we_n_s;
    assign rd_start = rd_act && !rd_prev_q;
    assign wr_start = wr_act && !wr_prev_q;

    // Registers the previous strobe levels for edge detection.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_prev_q <= 1'b0;
            wr_prev_q <= 1'b0;
        end else begin
            rd_prev_q <= rd_act;
            wr_prev_q <= wr_act;
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    putk_pkg::putk_state_e state_q, state_d;   // Sequencer state.
    logic [5:0]            ptr_q,   ptr_d;     // Key or transfer bit index.
    logic [63:0]           shadow_q, shadow_d; // Incoming transfer bits.
    logic                  upd_q,   upd_d;     // Commit pulse.
    logic                  abort_ok;           // Abort pin honoured.
    logic                  push_v;             // Push a read bit.
    logic                  buf_ready;          // Buffer can take a bit.
    logic [63:0]           time_q,  time_d;    // Time image.

    // Abort pin only counts while the ignore bit in the day register is 0.
    assign abort_ok = !abort_n_s
        && !time_q[putk_pkg::DAY_REG*putk_pkg::REG_WIDTH + putk_pkg::RST_EN_BIT];

    // Computes the next state, pointer and captured bits.
    always_comb begin
        state_d  = state_q;
        ptr_d    = ptr_q;
        shadow_d = shadow_q;
        upd_d    = 1'b0;
        push_v   = 1'b0;
        if (pfail_s) begin
            // Supply low: drop any attempt, refuse access until it clears.
            state_d = putk_pkg::PUTK_IDLE;
            ptr_d   = putk_pkg::PTR_RESET;
        end else if (abort_ok && state_q == putk_pkg::PUTK_XFER) begin
            // Abort pin ends the transfer, time image untouched.
            state_d = putk_pkg::PUTK_IDLE;
            ptr_d   = putk_pkg::PTR_RESET;
        end else begin
            unique case (state_q)
                putk_pkg::PUTK_IDLE, putk_pkg::PUTK_MATCH, putk_pkg::PUTK_DEAD: begin
                    if (rd_start) begin
                        // Any read restarts recognition from bit zero.
                        state_d = putk_pkg::PUTK_MATCH;
                        ptr_d   = putk_pkg::PTR_RESET;
                    end else if (wr_start && state_q == putk_pkg::PUTK_MATCH) begin
                        if (din_s == putk_pkg::UNLOCK_KEY[ptr_q]) begin
                            // Match: step on; full key opens the transfer.
                            ptr_d = ptr_q + 6'h01;
                            if (ptr_q == 6'h3F) begin
                                state_d = putk_pkg::PUTK_XFER;
                            end
                        end else begin
                            // Mismatch: hold pointer and ignore writes.
                            state_d = putk_pkg::PUTK_DEAD;
                        end
                    end
                end
                putk_pkg::PUTK_XFER: begin
                    if ((wr_start || rd_start) && (wr_start || buf_ready)) begin
                        if (wr_start) begin
                            shadow_d[ptr_q] = din_s;
                        end else begin
                            push_v = 1'b1;
                        end
                        ptr_d = ptr_q + 6'h01;
                        if (ptr_q == 6'h3F) begin
                            // Last transfer: relock; if it is a write, commit written bits.
                            state_d = putk_pkg::PUTK_IDLE;
                            upd_d   = wr_start;
                        end
                    end
                end
            endcase
        end
    end

    // Time image reloads time_load_i each cycle; a completed write transfer overrides it, key writes never do.
    always_comb begin
        time_d = time_load_i;
        if (upd_q) begin
            time_d = shadow_q;
        end
    end

    // Registers the sequencer and image.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q  <= putk_pkg::PUTK_IDLE;
            ptr_q    <= putk_pkg::PTR_RESET;
            shadow_q <= putk_pkg::TIME_RESET;
            upd_q    <= 1'b0;
            time_q   <= putk_pkg::TIME_RESET;
        end else begin
            state_q  <= state_d;
            ptr_q    <= ptr_d;
            shadow_q <= shadow_d;
            upd_q    <= upd_d;
            time_q   <= time_d;
        end
    end

    // ************************************************************
    // Read bit buffer
    // ************************************************************
    logic flush;   // Drop queued bits on abort.
    assign flush = pfail_s || abort_ok;

    putk_buf2 #(.WIDTH(1)) u_buf (
        .mclk_i      (mclk_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (push_v),
        .in_ready_o  (buf_ready),
        .in_data_i   (time_q[ptr_q]),
        .out_valid_o (rd_bit_valid_o),
        .out_ready_i (rd_bit_ready_i),
        .out_data_o  (rd_bit_o),
        .flush_i     (flush)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    logic cso_q,  cso_d;  // Memory select, registered.
    logic dq_q,   dq_d;   // Serial output bit.
    logic doe_q,  doe_d;  // Serial output enable.
    logic hold_q, hold_d; // Cycle begun in the transfer phase still selected.

    // Computes the memory select and serial pin drive.
    always_comb begin
        // The cycle that ends the phase stays a transfer until chip select drops,
        // so the memory is never selected part way through it.
        hold_d = !cs_n_s && (hold_q || state_q == putk_pkg::PUTK_XFER);
        dq_d   = dq_q;
        doe_d  = ((state_q == putk_pkg::PUTK_XFER) || hold_q) && rd_act && !pfail_s;
        if (push_v) begin
            dq_d = time_q[ptr_q];
        end
        if (pfail_s) begin
            // ROM mode drives low, RAM mode protects with high.
            cso_d = rom_s ? 1'b0 : 1'b1;
        end else if (state_q == putk_pkg::PUTK_XFER || hold_q) begin
            cso_d = 1'b1;
        end else begin
            cso_d = cs_n_s;
        end
    end

    // Registers the pin drive.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cso_q  <= 1'b1;
            dq_q   <= 1'b0;
            doe_q  <= 1'b0;
            hold_q <= 1'b0;
        end else begin
            cso_q  <= cso_d;
            dq_q   <= dq_d;
            doe_q  <= doe_d;
            hold_q <= hold_d;
        end
    end

    assign memory_select_out_n_o = cso_q;
    assign serial_out_o          = dq_q;
    assign serial_out_oe_o       = doe_q;
    assign time_image_o          = time_q;
    assign time_update_o         = upd_q;
    assign unlocked_o            = (state_q == putk_pkg::PUTK_XFER);
endmodule
`default_nettype wire

/* File: sim/putk_checker.sv */
/* Concurrent checks on the access sequencer's pins.
   Assumes one clock and the bind at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
// ******
// Checker
// ******
module putk_checker (
    // Clock, reset and pins from the host side.
    input wire logic        mclk_i, resetn_i, chip_select_in_n_i, abort_n_i,
    input wire logic        power_fail_i, rom_mode_i, rd_bit_ready_i,
    // Outputs under watch.
    input wire logic        memory_select_out_n_o, rd_bit_valid_o, rd_bit_o,
    input wire logic        time_update_o, unlocked_o,
    input wire logic [63:0] time_image_o
);
    // All checks share the one clock and reset.
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    // Set while a cycle that began in the transfer phase still holds chip select.
    logic tail_q;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tail_q <= 1'b0;
        end else begin
            tail_q <= (unlocked_o || tail_q) && !chip_select_in_n_i;
        end
    end
    // The transfer phase keeps the memory deselected.
    property p_xfer_ms;
        unlocked_o [*3] |-> memory_select_out_n_o;
    endproperty
    a_xfer_ms: assert property (p_xfer_ms) else $error("select low in transfer");
    // Locked, normal supply: the select mirrors chip select.
    property p_follow;
        (!power_fail_i && !unlocked_o && !tail_q && $stable(chip_select_in_n_i)) [*5]
            |-> memory_select_out_n_o == chip_select_in_n_i;
    endproperty
    a_follow: assert property (p_follow) else $error("select not tracking");
    // RAM mode power fail holds the select high.
    property p_pf_ram;
        (power_fail_i && !rom_mode_i) [*5] |-> memory_select_out_n_o;
    endproperty
    a_pf_ram: assert property (p_pf_ram) else $error("RAM select not high");
    // ROM mode power fail holds the select low.
    property p_pf_rom;
        (power_fail_i && rom_mode_i) [*5] |-> !memory_select_out_n_o;
    endproperty
    a_pf_rom: assert property (p_pf_rom) else $error("ROM select not low");
    // Power fail ends any transfer in either mode.
    property p_pf_lock;
        power_fail_i [*5] |-> !unlocked_o;
    endproperty
    a_pf_lock: assert property (p_pf_lock) else $error("open under power fail");
    // A stalled head bit stays put unless a flush is coming.
    property p_hold;
        rd_bit_valid_o && !rd_bit_ready_i && !power_fail_i && !$past(power_fail_i)
            && !$past(power_fail_i, 2) && $past(abort_n_i)
            |=> rd_bit_valid_o && $stable(rd_bit_o);
    endproperty
    a_hold: assert property (p_hold) else $error("stalled bit lost");
    // A commit only follows a transfer phase.
    property p_upd_src;
        time_update_o |-> $past(unlocked_o, 2);
    endproperty
    a_upd_src: assert property (p_upd_src) else $error("commit outside transfer");
    // Abort pin ends the transfer when the day bit is clear.
    property p_abort;
        $fell(abort_n_i) && unlocked_o && !time_image_o[36] |-> ##[1:5] !unlocked_o;
    endproperty
    a_abort: assert property (p_abort) else $error("abort not taken");
    // Main scenarios reached.
    c_unlock: cover property ($rose(unlocked_o));
    c_commit: cover property (time_update_o);
    c_stall: cover property (rd_bit_valid_o && !rd_bit_ready_i);
endmodule
bind putk_top putk_checker u_chk (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .chip_select_in_n_i(chip_select_in_n_i),
    .abort_n_i(abort_n_i), .power_fail_i(power_fail_i), .rom_mode_i(rom_mode_i),
    .rd_bit_ready_i(rd_bit_ready_i), .memory_select_out_n_o(memory_select_out_n_o),
    .rd_bit_valid_o(rd_bit_valid_o), .rd_bit_o(rd_bit_o), .unlocked_o(unlocked_o),
    .time_update_o(time_update_o), .time_image_o(time_image_o)
);
`default_nettype wire

/* File: sim/putk_far_model.sv */
/* Far side: counting logic that keeps the time, and a sink for read bits.
   Assumes the sequencer's clock and reset. */
`timescale 1ns/1ps
`default_nettype none
// ******
// Far side
// ******
module putk_far_model #(
    parameter logic [63:0] INIT = 64'h0000_0000_0000_0000 // Time held at reset.
) (
    // Clock, reset and sink stall.
    input  wire logic        mclk_i, resetn_i, stall_i,
    // Sequencer side.
    input  wire logic [63:0] time_image_i,
    input  wire logic        time_update_i, rd_bit_valid_i, rd_bit_i,
    output logic             rd_bit_ready_o,
    output logic      [63:0] time_load_o, cap_o,
    output logic      [6:0]  cap_n_o
);
    logic        upd_q;  // Commit seen last cycle; image now holds it.
    logic [63:0] load_q; // Time kept by the counter.
    assign rd_bit_ready_o = !stall_i;
    // Hand the committed image straight back so the reload cannot undo it.
    assign time_load_o = upd_q ? time_image_i : load_q;
    // Counter takes committed time; sink stores drained bits in order.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            upd_q   <= 1'b0;
            load_q  <= INIT;
            cap_o   <= 64'h0000_0000_0000_0000;
            cap_n_o <= 7'h00;
        end else begin
            upd_q  <= time_update_i;
            load_q <= time_load_o;
            if (rd_bit_valid_i && !stall_i) begin
                cap_o[cap_n_o[5:0]] <= rd_bit_i;
                cap_n_o             <= cap_n_o + 7'h01;
            end
        end
    end
endmodule
`default_nettype wire

/* File: sim/putk_top_test.sv */
/* Self-checking bench for the access sequencer.
   Assumes putk_top, putk_far_model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
// ******
// Bench
// ******
module putk_top_test;
    localparam logic [63:0] INIT = 64'h0123_4567_0089_ABCD; // Outside time, day bit clear.
    localparam logic [63:0] WVAL = 64'h5544_3322_1100_9988; // Written time, day bit clear.
    // Locked rows: ROM mode, power fail, chip select n, expected select n.
    localparam logic [3:0] ROWS [6] = '{4'h0, 4'h3, 4'h5, 4'hC, 4'hE, 4'h8};
    logic        mclk_i = 1'b0, resetn_i = 1'b0, cs_n = 1'b1, oe_n = 1'b1, we_n = 1'b1;
    logic        si = 1'b0, abort_n = 1'b1, pf = 1'b0, rom = 1'b0, stall = 1'b0;
    logic        ms_n, so, so_oe, rv, rr, rb, upd, unl;
    logic [63:0] load, img, cap;
    logic [6:0]  cap_n;
    int          err_count = 0, checked = 0, upd_seen = 0;
    putk_top dut (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .chip_select_in_n_i(cs_n),
        .output_gate_n_i(oe_n), .write_enable_n_i(we_n), .serial_in_i(si),
        .abort_n_i(abort_n), .power_fail_i(pf), .rom_mode_i(rom),
        .memory_select_out_n_o(ms_n), .serial_out_o(so), .serial_out_oe_o(so_oe),
        .rd_bit_valid_o(rv), .rd_bit_ready_i(rr), .rd_bit_o(rb), .time_load_i(load),
        .time_image_o(img), .time_update_o(upd), .unlocked_o(unl)
    );
    putk_far_model #(.INIT(INIT)) far (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .stall_i(stall), .time_image_i(img),
        .time_update_i(upd), .rd_bit_valid_i(rv), .rd_bit_i(rb), .rd_bit_ready_o(rr),
        .time_load_o(load), .cap_o(cap), .cap_n_o(cap_n)
    );
    // Free-running 200 MHz clock.
    initial forever #2.5 mclk_i = ~mclk_i;
    // Commit pulses are counted as they pass.
    always @(negedge mclk_i) if (upd === 1'b1) upd_seen++;
    // Compare one value and report a mismatch at once.
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Verdict and end of run.
    task automatic complete_run();
        if (err_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Wait n edges, then step just past the last one.
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // One bus cycle: strobes held five edges, idle four; transfer keeps memory off.
    task automatic cyc(input logic rd, input logic cs, input logic d);
        logic u;
        tick(1);
        u = unl;
        {cs_n, oe_n, we_n, si} = {!cs, !rd, rd, d};
        tick(5);
        if (cs && u === 1'b1) chk("select_xfer", 64'h1, 64'(ms_n));
        if (cs && rd && u === 1'b1) chk("serial_oe", 64'h1, 64'(so_oe));
        {cs_n, oe_n, we_n} = 3'h7;
        tick(4);
    endtask
    // Key writes from bit 0; a foreign cycle at bit 20; bit bad first sent wrong.
    task automatic key(input int n, input int bad);
        for (int k = 0; k < n; k++) begin
            if (k == 20) cyc(1'b0, 1'b0, !putk_pkg::UNLOCK_KEY[k]);
            if (k == bad) cyc(1'b0, 1'b1, !putk_pkg::UNLOCK_KEY[k]);
            cyc(1'b0, 1'b1, putk_pkg::UNLOCK_KEY[k]);
        end
    endtask
    // Opening read, full key, then the phase must be open.
    task automatic unlock();
        cyc(1'b1, 1'b1, 1'b0);
        key(64, -1);
        chk("unlocked", 64'h1, 64'(unl));
    endtask
    // Transfer writes of the low n bits of v.
    task automatic wr(input logic [63:0] v, input int n);
        for (int k = 0; k < n; k++) cyc(1'b0, 1'b1, v[k]);
    endtask
    // Watchdog well past the expected run length.
    initial begin
        #100000;
        err_count++;
        complete_run();
    end
    // Reset, the mode table, then the hand-written cases.
    initial begin
        tick(7);
        chk("rst_select", 64'h1, 64'(ms_n));
        chk("rst_unlocked", 64'h0, 64'(unl));
        chk("rst_valid", 64'h0, 64'(rv));
        chk("rst_oe", 64'h0, 64'(so_oe));
        chk("rst_image", 64'h0, img);
        tick(1);
        resetn_i = 1'b1;
        foreach (ROWS[i]) begin
            {rom, pf, cs_n} = ROWS[i][3:1];
            tick(6);
            chk("select_mode", 64'(ROWS[i][0]), 64'(ms_n));
        end
        {rom, pf, cs_n} = 3'h1;
        cyc(1'b1, 1'b1, 1'b0);
        key(30, -1);
        unlock();
        wr(~WVAL, 10);
        pf = 1'b1;
        tick(8);
        chk("pf_unlocked", 64'h0, 64'(unl));
        chk("pf_select", 64'h1, 64'(ms_n));
        pf = 1'b0;
        tick(8);
        chk("pf_image", INIT, img);
        cyc(1'b1, 1'b1, 1'b0);
        key(64, 5);
        chk("bad_key", 64'h0, 64'(unl));
        unlock();
        chk("key_image", INIT, img);
        wr(WVAL, 64);
        chk("commit", 64'h1, 64'(upd_seen));
        chk("image", WVAL, img);
        chk("relock", 64'h0, 64'(unl));
        key(64, -1);
        chk("no_read", 64'h0, 64'(unl));
        unlock();
        stall = 1'b1;
        repeat (3) cyc(1'b1, 1'b1, 1'b0);
        chk("full_valid", 64'h1, 64'(rv));
        chk("full_count", 64'h0, 64'(cap_n));
        stall = 1'b0;
        for (int k = 2; k < 64; k++) begin
            cyc(1'b1, 1'b1, 1'b0);
            chk("serial_out", 64'(WVAL[k]), 64'(so));
        end
        chk("read_bits", WVAL, cap);
        chk("read_relock", 64'h0, 64'(unl));
        unlock();
        wr(~WVAL, 10);
        abort_n = 1'b0;
        tick(6);
        abort_n = 1'b1;
        chk("abort_unlocked", 64'h0, 64'(unl));
        chk("abort_image", WVAL, img);
        complete_run();
    end
endmodule
`default_nettype wire
